/* rtl/tc16_timer.sv */
// 16-bit timer/counter with prescaler, compare reset and AHB-Lite registers
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tc16_params.svh"

module tc16_timer (
  // clock and power-on reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // other device resets (one-cycle pulse, hclk domain)
  input  wire logic                soft_reset,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // external clock pins
  input  wire logic                external_clock_pin,
  input  wire logic                osc_input_pin,
  // core state and compare units
  input  wire logic                sleep_mode,
  input  wire tc16_pkg::tc16_cmp_t compare_unit_one,
  input  wire tc16_pkg::tc16_cmp_t compare_unit_two,
  // results
  output logic      [15:0]         count_value,
  output logic                     timebase_valid,
  output logic                     osc_amp_enable,
  output logic                     overflow_irq
);
  import tc16_pkg::*;

  // registers, pipeline stages and decoded strobes
  tc16_ctrl_t  ctrl;
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic [15:0] count;
  logic        pin_s1;
  logic        pin_s2;
  logic        pin_s3;
  logic        pin_lvl;
  logic        pin_lvl_prev;
  logic        ext_rise;
  logic [2:0]  presc;
  logic [2:0]  presc_mask;
  logic        presc_step;
  logic        presc_wrap;
  logic        presc_tgl;
  logic        tgl_s1;
  logic        tgl_s2;
  logic        tgl_s3;
  logic        sync_pulse;
  logic        async_mode;
  logic        tick;
  logic        special_event;
  logic        overflow_set;
  tc16_bus_t   bus_state;
  logic        take;
  logic        dp_wr;
  logic [29:0] wr_idx;
  logic [29:0] rd_idx;
  logic [7:0]  wdata;
  logic        wr_count_low;
  logic        wr_count_high;
  logic        wr_count;
  logic        wr_control;
  logic        wr_flags;
  logic        wr_enables;

  // bus decode
  // every register is one aligned word; hsize is not checked
  // reads wait one cycle so a write in the cycle before is seen

  // a transfer is taken on an active address phase while the bus is ready
  assign take  = hsel && hready && htrans[1];
  assign wdata = hwdata[7:0];

  // write strobes act in the data phase, the cycle after the address phase
  assign wr_count_low  = dp_wr && (wr_idx == `TC16_IDX_COUNT_LOW);
  assign wr_count_high = dp_wr && (wr_idx == `TC16_IDX_COUNT_HIGH);
  assign wr_count      = wr_count_low || wr_count_high;
  assign wr_control    = dp_wr && (wr_idx == `TC16_IDX_CONTROL);
  assign wr_flags      = dp_wr && (wr_idx == `TC16_IDX_IRQ_FLAGS);
  assign wr_enables    = dp_wr && (wr_idx == `TC16_IDX_IRQ_ENABLES);

  // write address phase capture; writes need no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr  <= 1'b0;
      wr_idx <= 30'h00000000;
    end else begin
      dp_wr <= take && hwrite;
      if (take && hwrite) begin
        wr_idx <= haddr[31:2];
      end
    end
  end

  // read mux; unmapped words and unused upper bits read as zero
  function automatic logic [31:0] read_mux(input logic [29:0] idx);
    logic [31:0] r;
    r = 32'h00000000;
    case (idx)
      `TC16_IDX_COUNT_LOW:   r[7:0] = count[7:0];
      `TC16_IDX_COUNT_HIGH:  r[7:0] = count[15:8];
      `TC16_IDX_CONTROL:     r[`TC16_CTRL_WIDTH-1:0] = ctrl;
      `TC16_IDX_IRQ_FLAGS:   r[`TC16_BIT_OVERFLOW] = overflow_flag;
      `TC16_IDX_IRQ_ENABLES: r[`TC16_BIT_OVERFLOW] = overflow_irq_enable;
      default:               r = 32'h00000000;
    endcase
    return r;
  endfunction

  // reads take one wait state so a write in the previous data phase is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= TC16_BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      rd_idx    <= 30'h00000000;
    end else begin
      case (bus_state)
        TC16_BUS_IDLE: begin
          if (take && !hwrite) begin
            rd_idx    <= haddr[31:2];
            hreadyout <= 1'b0;
            bus_state <= TC16_BUS_RDWAIT;
          end
        end
        TC16_BUS_RDWAIT: begin
          hrdata    <= read_mux(rd_idx);
          hreadyout <= 1'b1;
          bus_state <= TC16_BUS_IDLE;
        end
        default: begin
          hreadyout <= 1'b1;
          bus_state <= TC16_BUS_IDLE;
        end
      endcase
    end
  end

  // every answer is OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // control and enables
  // control survives the other resets; the interrupt enable does not
  // the oscillator amplifier follows its enable one cycle late

  // only power-on reset clears control; the other resets leave it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `TC16_RST_CONTROL;
    end else if (wr_control) begin
      ctrl <= wdata[`TC16_CTRL_WIDTH-1:0];
    end
  end

  // interrupt enable is cleared by every reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq_enable <= `TC16_RST_IRQ;
    end else if (soft_reset) begin
      overflow_irq_enable <= `TC16_RST_IRQ;
    end else if (wr_enables) begin
      overflow_irq_enable <= wdata[`TC16_BIT_OVERFLOW];
    end
  end

  // the oscillator is analog; this only switches its amplifier, kept on in sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_amp_enable <= 1'b0;
    end else begin
      osc_amp_enable <= ctrl.oscillator_enable;
    end
  end

  // external source with the synchroniser bypassed
  assign async_mode = ctrl.clock_source_select && ctrl.sync_disable;

  // external clock input
  // the selected pin passes three flops before it counts as a level
  // levels shorter than one clock never reach the counter

  // pin choice before the filter; an oscillator switch may give one false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1       <= 1'b0;
      pin_s2       <= 1'b0;
      pin_s3       <= 1'b0;
      pin_lvl      <= 1'b0;
      pin_lvl_prev <= 1'b0;
    end else begin
      pin_s1 <= ctrl.oscillator_enable ? osc_input_pin : external_clock_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_lvl <= pin_s3;
      end
      pin_lvl_prev <= pin_lvl;
    end
  end

  // one-cycle pulse on each filtered rising level
  assign ext_rise = pin_lvl && !pin_lvl_prev;

  // prescaler
  // a count byte write clears it, so the first tick after a write is a full period
  // its output toggles once per wrap and is what gets synchronised

  // divide mask: 1:1, 1:2, 1:4, 1:8
  always_comb begin
    case (ctrl.input_prescale_select)
      2'h0:    presc_mask = 3'h0;
      2'h1:    presc_mask = 3'h1;
      2'h2:    presc_mask = 3'h3;
      default: presc_mask = 3'h7;
    endcase
  end

  // internal clock stops in sleep; external edges still step the prescaler then
  assign presc_step = ctrl.run_enable
                    && (ctrl.clock_source_select ? ext_rise : !sleep_mode);
  assign presc_wrap = presc_step && ((presc & presc_mask) == presc_mask);

  // prescaler counter; a count byte write restarts it from zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc     <= 3'h0;
      presc_tgl <= 1'b0;
    end else begin
      if (wr_count) begin
        presc <= 3'h0;
      end else if (presc_wrap) begin
        presc <= 3'h0;
      end else if (presc_step) begin
        presc <= presc + 3'h1;
      end
      if (presc_wrap) begin
        presc_tgl <= !presc_tgl;
      end
    end
  end

  // prescaler output crosses a two-stage synchroniser; each change is one pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= presc_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // each toggle seen at the synchroniser output is one increment
  assign sync_pulse = tgl_s2 ^ tgl_s3;

  // count
  // a byte write beats a special event, which beats an increment
  // the count flops have no reset and start unknown

  // synchroniser output is masked in sleep, so the synchronised path stops there
  always_comb begin
    if (!ctrl.clock_source_select) begin
      tick = presc_wrap;
    end else if (ctrl.sync_disable) begin
      tick = presc_wrap;
    end else begin
      tick = sync_pulse && !sleep_mode && ctrl.run_enable;
    end
  end

  // unsupported in asynchronous mode, so the trigger is ignored there
  assign special_event = !async_mode
    && ((compare_unit_one.match
         && (compare_unit_one.compare_mode_field == `TC16_CMP_SPECIAL_EVENT))
     || (compare_unit_two.match
         && (compare_unit_two.compare_mode_field == `TC16_CMP_SPECIAL_EVENT)));

  // no reset on purpose: the count survives every reset
  always_ff @(posedge hclk) begin
    if (wr_count_low) begin
      count[7:0] <= wdata;
    end else if (wr_count_high) begin
      count[15:8] <= wdata;
    end else if (special_event) begin
      count <= `TC16_COUNT_ZERO;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // rollover by increment only, never by special event reset or write
  assign overflow_set = tick && !wr_count && !special_event
                      && (count == `TC16_COUNT_MAX);

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= `TC16_RST_IRQ;
    end else if (overflow_set) begin
      overflow_flag <= 1'b1;
    end else if (soft_reset) begin
      overflow_flag <= `TC16_RST_IRQ;
    end else if (wr_flags) begin
      overflow_flag <= wdata[`TC16_BIT_OVERFLOW];
    end
  end

  // interrupt request; also asserted in sleep so it can wake the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  // time base flag for capture and compare units
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timebase_valid <= 1'b1;
    end else begin
      timebase_valid <= !async_mode;
    end
  end

  // the count leaves straight from its flops
  assign count_value = count;

endmodule
`default_nettype wire

/* rtl/tc16_params.svh */
// offsets, field positions, reset values and codes of the 16-bit timer/counter
`ifndef TC16_PARAMS_SVH
`define TC16_PARAMS_SVH

// register indices; byte address is four times the index
`define TC16_IDX_IRQ_FLAGS     30'h0000000C
`define TC16_IDX_COUNT_LOW     30'h0000000E
`define TC16_IDX_COUNT_HIGH    30'h0000000F
`define TC16_IDX_CONTROL       30'h00000010
`define TC16_IDX_IRQ_ENABLES   30'h0000008C

// field positions
`define TC16_BIT_OVERFLOW      0
`define TC16_CTRL_WIDTH        6

// reset values
`define TC16_RST_CONTROL       6'h00
`define TC16_RST_IRQ           1'h0

// compare mode code that asks for the special event trigger
`define TC16_CMP_SPECIAL_EVENT 4'hB

// count limits
`define TC16_COUNT_MAX         16'hFFFF
`define TC16_COUNT_ZERO        16'h0000

`endif

/* rtl/tc16_pkg.sv */
// types shared by the 16-bit timer/counter
`default_nettype none
package tc16_pkg;

  // counter_control layout, bit 5 downward
  typedef struct packed {
    logic [1:0] input_prescale_select;
    logic       oscillator_enable;
    logic       sync_disable;
    logic       clock_source_select;
    logic       run_enable;
  } tc16_ctrl_t;

  // what a compare unit tells the timer
  typedef struct packed {
    logic [3:0] compare_mode_field;
    logic       match;
  } tc16_cmp_t;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    TC16_BUS_IDLE   = 2'b01,
    TC16_BUS_RDWAIT = 2'b10
  } tc16_bus_t;

endpackage
`default_nettype wire

/* tb/tc16_clk_src.sv */
// far-side model: external clock pin and low-power oscillator input
`timescale 1ns/1ps
`default_nettype none
module tc16_clk_src (
  // pins into the timer
  output logic external_clock_pin,
  output logic osc_input_pin
);
  // both pins idle low between bursts, so each burst opens with a rising edge
  initial begin
    external_clock_pin = 1'b0;
    osc_input_pin = 1'b0;
  end
  // n full cycles on one pin; half sets fast or slow edges
  task automatic burst(input logic osc, input int n, input int half);
    repeat (n) begin
      #half;
      if (osc) osc_input_pin = 1'b1;
      else external_clock_pin = 1'b1;
      #half;
      if (osc) osc_input_pin = 1'b0;
      else external_clock_pin = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* tb/tc16_timer_sva.sv */
// port checker of the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tc16_timer_sva (
  // bus
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // compare units and results
  input wire tc16_pkg::tc16_cmp_t compare_unit_one,
  input wire tc16_pkg::tc16_cmp_t compare_unit_two,
  input wire logic [15:0]         count_value,
  input wire logic                timebase_valid,
  input wire logic                osc_amp_enable
);
  import tc16_pkg::*;
  logic        dw;
  logic [11:0] da;
  logic [5:0]  ctrl_m;
  logic        wr_lo;
  logic        wr_hi;
  logic        sev;
  logic        async_m;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // mirror of control: data phase lands one edge after the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dw <= 1'b0;
      da <= 12'h000;
      ctrl_m <= 6'h00;
    end else begin
      dw <= hsel && hready && htrans[1] && hwrite;
      da <= haddr[11:0];
      if (dw && da == 12'h040) ctrl_m <= hwdata[5:0];
    end
  end
  // decoded events; async mode excluded from trigger checks
  assign wr_lo = dw && (da == 12'h038);
  assign wr_hi = dw && (da == 12'h03C);
  assign async_m = ctrl_m[1] && ctrl_m[2];
  assign sev = (compare_unit_one.match && compare_unit_one.compare_mode_field == 4'hB)
            || (compare_unit_two.match && compare_unit_two.compare_mode_field == 4'hB);
  sequence rd_taken_s;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (rd_taken_s |=> one_wait_s)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  timebase_a: assert property ($stable(ctrl_m) |-> timebase_valid == !async_m)
    else $error("timebase flag wrong");
  osc_amp_a: assert property ($stable(ctrl_m) |-> osc_amp_enable == ctrl_m[3])
    else $error("oscillator enable wrong");
  sev_clear_a: assert property (sev && !wr_lo && !wr_hi && !async_m |=> count_value == 16'h0000)
    else $error("trigger did not clear count");
  wr_low_a: assert property (wr_lo |=> count_value[7:0] == $past(hwdata[7:0]))
    else $error("low byte write lost");
  wr_high_a: assert property (wr_hi |=> count_value[15:8] == $past(hwdata[7:0]))
    else $error("high byte write lost");
endmodule
bind tc16_timer tc16_timer_sva tc16_timer_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .compare_unit_one, .compare_unit_two,
  .count_value, .timebase_valid, .osc_amp_enable);
`default_nettype wire

/* tb/tc16_timer_tb_top.sv */
// self-checking bench of the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tc16_timer_tb_top;
  import tc16_pkg::*;
  logic        hclk, hresetn, soft_reset, hsel, hwrite, hreadyout, hresp, pend;
  logic        external_clock_pin, osc_input_pin, sleep_mode;
  logic        timebase_valid, osc_amp_enable, overflow_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] count_value, v;
  logic [7:0]  m;
  logic [7:0]  mt [5];
  tc16_cmp_t   compare_unit_one, compare_unit_two;
  logic [31:0] exp_q [$];
  int          n_fail, tests_run, n, i;
  wire         hready = hreadyout;
  tc16_timer tc16_timer_i (.hclk, .hresetn, .soft_reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .external_clock_pin,
    .osc_input_pin, .sleep_mode, .compare_unit_one, .compare_unit_two, .count_value,
    .timebase_valid, .osc_amp_enable, .overflow_irq);
  tc16_clk_src tc16_clk_src_i (.external_clock_pin, .osc_input_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic end_of_test;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // address phase held until the slave is ready
  task automatic ap(input logic [11:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask
  // sv raises a trigger on unit one in the write's data phase
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic sv);
    ap(a, 1'b1);
    hwdata <= d;
    compare_unit_one.match <= sv;
    do @(posedge hclk); while (hready !== 1'b1);
    compare_unit_one.match <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    ap(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  task automatic pulse(input int u);
    @(posedge hclk);
    if (u == 1) compare_unit_one.match <= 1'b1;
    else compare_unit_two.match <= 1'b1;
    @(posedge hclk);
    compare_unit_one.match <= 1'b0;
    compare_unit_two.match <= 1'b0;
  endtask
  // edges until the count moves, bounded so a stuck count cannot hang
  task automatic gap(output int k);
    logic [15:0] s;
    #1;
    s = count_value;
    k = 0;
    while (count_value === s && k < 100) begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask
  // read data is compared against the oldest note when the data phase ends
  always @(posedge hclk) begin
    if (pend && hreadyout) begin
      chk(hrdata, exp_q.pop_front());
      pend = 1'b0;
    end
    if (hsel && hready && htrans[1] && !hwrite) pend = 1'b1;
  end
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    #100us;
    n_fail++;
    end_of_test;
  end
  // main sequence
  initial begin
    {hresetn, soft_reset, hsel, hwrite, sleep_mode, pend} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    compare_unit_one = 5'h16;
    compare_unit_two = 5'h16;
    mt = '{8'h03, 8'h0B, 8'h07, 8'h87, 8'h83};
    void'($urandom(32'h69F7));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h040, 32'h0);
    rd(12'h030, 32'h0);
    rd(12'h230, 32'h0);
    rd(12'h044, 32'h0);
    chk(timebase_valid, 32'h1);
    v = 16'($urandom);
    wr(12'h038, {24'h0, v[7:0]}, 1'b0);
    wr(12'h03C, {24'h0, v[15:8]}, 1'b0);
    rd(12'h038, {24'h0, v[7:0]});
    rd(12'h03C, {24'h0, v[15:8]});
    chk(count_value, v);
    // timer mode with the sync bit set, which must not matter
    for (i = 0; i < 4; i++) begin
      wr(12'h040, {26'h0, i[1:0], 4'h5}, 1'b0);
      wr(12'h038, $urandom & 32'hFF, 1'b0);
      gap(n);
      chk(n, 1 << i);
    end
    wr(12'h040, 32'h0, 1'b0);
    cyc(3);
    v = count_value;
    cyc(20);
    chk(count_value, v);
    wr(12'h230, 32'h1, 1'b0);
    wr(12'h038, 32'hFF, 1'b0);
    wr(12'h03C, 32'hFF, 1'b0);
    wr(12'h040, 32'h1, 1'b0);
    cyc(3);
    chk(overflow_irq, 32'h1);
    wr(12'h040, 32'h0, 1'b0);
    rd(12'h030, 32'h1);
    wr(12'h030, 32'h0, 1'b0);
    rd(12'h030, 32'h0);
    chk(overflow_irq, 32'h0);
    for (i = 1; i < 3; i++) begin
      wr(12'h038, 32'h5A, 1'b0);
      pulse(i);
      cyc(1);
      chk(count_value, 32'h0);
      rd(12'h030, 32'h0);
    end
    // trigger lands on the edge that would wrap FFFF, so no flag may follow
    wr(12'h03C, 32'hFF, 1'b0);
    wr(12'h038, 32'hFE, 1'b0);
    wr(12'h040, 32'h1, 1'b0);
    pulse(1);
    wr(12'h040, 32'h0, 1'b0);
    chk(count_value[15:8], 32'h0);
    rd(12'h030, 32'h0);
    compare_unit_two.compare_mode_field <= 4'($urandom % 11);
    wr(12'h038, 32'h5A, 1'b0);
    pulse(2);
    cyc(1);
    chk(count_value[7:0], 32'h5A);
    compare_unit_two.compare_mode_field <= 4'hB;
    wr(12'h03C, 32'h12, 1'b0);
    wr(12'h038, 32'h34, 1'b1);
    cyc(1);
    chk(count_value, 32'h1234);
    wr(12'h040, 32'h30, 1'b0);
    @(posedge hclk);
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    cyc(1);
    chk(count_value, 32'h1234);
    rd(12'h040, 32'h30);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(1);
    chk(count_value, 32'h1234);
    rd(12'h040, 32'h0);
    // pin-driven modes; bit 7 of a row means sleep
    for (i = 0; i < 5; i++) begin
      m = mt[i];
      wr(12'h038, 32'h0, 1'b0);
      wr(12'h03C, 32'h0, 1'b0);
      wr(12'h040, {26'h0, m[5:0]}, 1'b0);
      sleep_mode <= m[7];
      // levels held several clocks so the three-flop filter passes each one
      tc16_clk_src_i.burst(m[3], 5, 112);
      cyc(8);
      chk(count_value, (m[7] && !m[2]) ? 5'd0 : 5'd5);
      chk(timebase_valid, !m[2]);
      chk(osc_amp_enable, m[3]);
      wr(12'h040, 32'h0, 1'b0);
      sleep_mode <= 1'b0;
    end
    end_of_test;
  end
endmodule
`default_nettype wire
